// [logic/ard_region_decoder.v]
// Address region decoder with its AXI4-Lite control registers.
// Assumes a core request port on ref_clk and a segment comparator outside that supplies the matched descriptor.
`include "ard_regs.vh"

module ard_region_decoder (
  input  wire        ref_clk,
  input  wire        rst_n,
  input  wire        core_req,
  input  wire [31:0] core_addr,
  input  wire        core_super,
  input  wire [15:0] segment_descriptor,
  output reg         dec_valid_r,
  output reg         vector_hit_r,
  output reg  [2:0]  vector_num_r,
  output reg         lsram_sel_r,
  output reg         cache_ram_sel_r,
  output reg  [8:0]  cfg_grp_sel_r,
  output reg  [7:0]  per_grp_sel_r,
  output reg         ext_sel_r,
  output reg  [2:0]  ext_bank_r,
  output reg         ext_cacheable_r,
  output reg         ext_halfword_r,
  output reg         reserved_hit_r,
  output reg         priv_fault_r,
  input  wire [31:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [31:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready
);

  // Only the placement and cache control bytes and the read-only status word live here; every other register sits in its own block.
  reg  [7:0]  local_sram_placement_r;
  reg  [7:0]  cache_ctrl_r;
  reg  [31:0] aw_addr_r;
  reg         aw_full_r;
  reg  [31:0] w_data_r;
  reg  [3:0]  w_strb_r;
  reg         w_full_r;

  wire place_hi = local_sram_placement_r[`ARD_PLACE_BIT];
  wire sram_mode = cache_ctrl_r[`ARD_CACHE_SRAM_BIT];

  // One hit per address window that the decoder tells apart; the vector window is compared directly.
  wire hit_lo;
  wire hit_hi;
  wire hit_cram;
  wire hit_rsv6;
  wire hit_cfg;
  wire hit_per;
  wire hit_per_used;
  wire hit_seg;
  wire hit_bank;
  wire hit_intc;
  wire hit_clk;

  // Each window is its own comparator, so moving a boundary touches one header line only.
  ard_span_hit #(.LO(`ARD_LSRAM_LO_BASE), .HI(`ARD_LSRAM_LO_TOP)) u_lo (
    .addr (core_addr),
    .hit  (hit_lo)
  );
  ard_span_hit #(.LO(`ARD_LSRAM_HI_BASE), .HI(`ARD_LSRAM_HI_TOP)) u_hi (
    .addr (core_addr),
    .hit  (hit_hi)
  );
  ard_span_hit #(.LO(`ARD_CRAM_BASE), .HI(`ARD_CRAM_TOP)) u_cram (
    .addr (core_addr),
    .hit  (hit_cram)
  );
  ard_span_hit #(.LO(`ARD_RSV6_BASE), .HI(`ARD_RSV6_TOP)) u_rsv6 (
    .addr (core_addr),
    .hit  (hit_rsv6)
  );

  // The two on-chip regions and the used part of the peripheral one.
  ard_span_hit #(.LO(`ARD_CFG_BASE), .HI(`ARD_CFG_TOP)) u_cfg (
    .addr (core_addr),
    .hit  (hit_cfg)
  );
  ard_span_hit #(.LO(`ARD_PER_BASE), .HI(`ARD_PER_TOP)) u_per (
    .addr (core_addr),
    .hit  (hit_per)
  );
  ard_span_hit #(.LO(`ARD_PER_BASE), .HI(`ARD_PER_USED_TOP)) u_per_used (
    .addr (core_addr),
    .hit  (hit_per_used)
  );

  // Register groups inside the configuration region.
  ard_span_hit #(.LO(`ARD_GRP_SEG_BASE), .HI(`ARD_GRP_SEG_TOP)) u_seg (
    .addr (core_addr),
    .hit  (hit_seg)
  );
  ard_span_hit #(.LO(`ARD_GRP_BANK_BASE), .HI(`ARD_GRP_BANK_TOP)) u_bank (
    .addr (core_addr),
    .hit  (hit_bank)
  );
  ard_span_hit #(.LO(`ARD_GRP_INTC_BASE), .HI(`ARD_GRP_INTC_TOP)) u_intc (
    .addr (core_addr),
    .hit  (hit_intc)
  );
  ard_span_hit #(.LO(`ARD_GRP_CLK_BASE), .HI(`ARD_GRP_CLK_TOP)) u_clk (
    .addr (core_addr),
    .hit  (hit_clk)
  );

  // Privilege comes from whichever segment matched, the default one included.
  wire priv_ok = core_super ? segment_descriptor[`ARD_SD_SUPER]
                            : segment_descriptor[`ARD_SD_USER];

  reg        vec_nxt;
  reg        lsram_nxt;
  reg        cram_nxt;
  reg [8:0]  cfg_nxt;
  reg [7:0]  per_nxt;
  reg        ext_nxt;
  reg        rsv_nxt;
  reg        onchip_nxt;

  // Decode looks at the address and the two control bits only; privilege is applied when the result is registered.
  always @* begin
    vec_nxt = (core_addr <= `ARD_VEC_TOP);
    lsram_nxt = place_hi ? hit_hi : hit_lo;
    cram_nxt = sram_mode && hit_cram;
    cfg_nxt = 9'h000;
    per_nxt = 8'h00;
    if (hit_cfg) begin
      cfg_nxt[`ARD_CFG_SEG] = hit_seg;
      cfg_nxt[`ARD_CFG_BANK] = hit_bank;
      cfg_nxt[`ARD_CFG_CACHE] = (core_addr == `ARD_CACHE_CTRL_ADDR);
      cfg_nxt[`ARD_CFG_LSRAM] = (core_addr == `ARD_LSRAM_CTRL_ADDR);
      cfg_nxt[`ARD_CFG_IDENT] = (core_addr == `ARD_IDENT_ADDR);
      cfg_nxt[`ARD_CFG_IO] = (core_addr == `ARD_IO_CFG_ADDR);
      cfg_nxt[`ARD_CFG_LCD] = (core_addr == `ARD_LCD_BIT_ADDR);
      cfg_nxt[`ARD_CFG_INTC] = hit_intc;
      cfg_nxt[`ARD_CFG_CLK] = hit_clk;
    end
    if (hit_per_used) begin
      per_nxt[core_addr[`ARD_PER_GRP_MSB:`ARD_PER_GRP_LSB]] = 1'b1;
    end
    // Unlisted addresses of either on-chip region fall out as reserved here.
    onchip_nxt = hit_cfg || hit_per;
    rsv_nxt = hit_rsv6 || (onchip_nxt && (cfg_nxt == 9'h000) && (per_nxt == 8'h00));
    ext_nxt = !onchip_nxt && !lsram_nxt && !cram_nxt && !hit_rsv6;
  end

  // Registering every result keeps decode glitches off the select lines, at the price of one cycle.
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      dec_valid_r <= 1'b0;
      vector_hit_r <= 1'b0;
      vector_num_r <= 3'h0;
      lsram_sel_r <= 1'b0;
      cache_ram_sel_r <= 1'b0;
      cfg_grp_sel_r <= 9'h000;
      per_grp_sel_r <= 8'h00;
      ext_sel_r <= 1'b0;
      ext_bank_r <= 3'h0;
      ext_cacheable_r <= 1'b0;
      ext_halfword_r <= 1'b0;
      reserved_hit_r <= 1'b0;
      priv_fault_r <= 1'b0;
    end else begin
      dec_valid_r <= core_req;
      if (core_req) begin
        vector_hit_r <= vec_nxt;
        // The vector number is taken on every request, so status always shows the last one.
        vector_num_r <= core_addr[`ARD_VEC_MSB:`ARD_VEC_LSB];
        // A fault blocks every select so a refused access touches nothing.
        priv_fault_r <= !priv_ok;
        lsram_sel_r <= priv_ok && lsram_nxt;
        cache_ram_sel_r <= priv_ok && cram_nxt;
        cfg_grp_sel_r <= priv_ok ? cfg_nxt : 9'h000;
        per_grp_sel_r <= priv_ok ? per_nxt : 8'h00;
        reserved_hit_r <= rsv_nxt;
        ext_sel_r <= priv_ok && ext_nxt;
        // Bank, cacheable and halfword only ever leave for external accesses.
        if (ext_nxt) begin
          ext_bank_r <= segment_descriptor[`ARD_SD_BANK_MSB:`ARD_SD_BANK_LSB];
          ext_cacheable_r <= segment_descriptor[`ARD_SD_CACHE];
          ext_halfword_r <= segment_descriptor[`ARD_SD_HALF];
        end else begin
          ext_bank_r <= 3'h0;
          ext_cacheable_r <= 1'b0;
          ext_halfword_r <= 1'b0;
        end
      end else begin
        vector_hit_r <= 1'b0;
        lsram_sel_r <= 1'b0;
        cache_ram_sel_r <= 1'b0;
        cfg_grp_sel_r <= 9'h000;
        per_grp_sel_r <= 8'h00;
        ext_sel_r <= 1'b0;
        reserved_hit_r <= 1'b0;
        priv_fault_r <= 1'b0;
      end
    end
  end

  // Write address and data are captured separately, so either may come first.
  // One write and one read at most are in flight, so no ordering logic is needed between them.
  assign s_axi_awready = !aw_full_r && !s_axi_bvalid;
  assign s_axi_wready = !w_full_r && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  // The response waits for both halves; nothing new is taken while it is pending.
  wire do_write = aw_full_r && w_full_r && !s_axi_bvalid;

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_addr_r <= `ARD_ZERO32;
      aw_full_r <= 1'b0;
      w_data_r <= `ARD_ZERO32;
      w_strb_r <= 4'h0;
      w_full_r <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `ARD_RESP_OKAY;
      local_sram_placement_r <= `ARD_PLACE_RST;
      cache_ctrl_r <= `ARD_CACHE_RST;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr_r <= s_axi_awaddr;
        aw_full_r <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
        w_full_r <= 1'b1;
      end
      if (do_write) begin
        aw_full_r <= 1'b0;
        w_full_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `ARD_RESP_OKAY;
        // Both registers are one byte wide, so only the low byte lane can change them.
        if (w_strb_r[`ARD_BYTE_LANE] && (aw_addr_r == `ARD_LSRAM_CTRL_ADDR)) begin
          local_sram_placement_r <= w_data_r[`ARD_BYTE_MSB:`ARD_BYTE_LSB];
        end
        if (w_strb_r[`ARD_BYTE_LANE] && (aw_addr_r == `ARD_CACHE_CTRL_ADDR)) begin
          cache_ctrl_r <= w_data_r[`ARD_BYTE_MSB:`ARD_BYTE_LSB];
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Status shows the previous cycle's decode result, letting software see where an address went; without a request only the vector number is kept.
  wire [8:0] status_w = {priv_fault_r, reserved_hit_r, ext_sel_r, cache_ram_sel_r, lsram_sel_r,
                         vector_hit_r, vector_num_r};

  // Unmapped reads answer OKAY with zero, so a stray probe cannot upset software.
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= `ARD_ZERO32;
      s_axi_rresp <= `ARD_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `ARD_RESP_OKAY;
      if (s_axi_araddr == `ARD_LSRAM_CTRL_ADDR) begin
        s_axi_rdata <= {`ARD_ZERO24, local_sram_placement_r};
      end else if (s_axi_araddr == `ARD_CACHE_CTRL_ADDR) begin
        s_axi_rdata <= {`ARD_ZERO24, cache_ctrl_r};
      end else if (s_axi_araddr == `ARD_STATUS_ADDR) begin
        s_axi_rdata <= {`ARD_ZERO23, status_w};
      end else begin
        s_axi_rdata <= `ARD_ZERO32;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule // ard_region_decoder

// [logic/ard_regs.vh]
// Address map constants for the address region decoder.
// Assumes a 32-bit byte address space and an AXI4-Lite register port.
`ifndef ARD_REGS_VH
`define ARD_REGS_VH

`define ARD_VEC_TOP       32'h0000001F
`define ARD_VEC_LSB       2
`define ARD_VEC_MSB       4

`define ARD_LSRAM_LO_BASE 32'h00000000
`define ARD_LSRAM_LO_TOP  32'h000007FF
`define ARD_LSRAM_HI_BASE 32'h60000000
`define ARD_LSRAM_HI_TOP  32'h600007FF
`define ARD_CRAM_BASE     32'h60000800
`define ARD_CRAM_TOP      32'h60000FFF
`define ARD_RSV6_BASE     32'h60001000
`define ARD_RSV6_TOP      32'h600017FF
`define ARD_PER_BASE      32'hFFFF0000
`define ARD_PER_TOP       32'hFFFF9FFF
`define ARD_PER_USED_TOP  32'hFFFF1FFF
`define ARD_CFG_BASE      32'hFFFFA000
`define ARD_CFG_TOP       32'hFFFFFFFF

`define ARD_GRP_SEG_BASE  32'hFFFFA000
`define ARD_GRP_SEG_TOP   32'hFFFFA0FF
`define ARD_GRP_BANK_BASE 32'hFFFFA100
`define ARD_GRP_BANK_TOP  32'hFFFFA1FF
`define ARD_GRP_INTC_BASE 32'hFFFFA800
`define ARD_GRP_INTC_TOP  32'hFFFFABFF
`define ARD_GRP_CLK_BASE  32'hFFFFAC00
`define ARD_GRP_CLK_TOP   32'hFFFFAFFF

`define ARD_CACHE_CTRL_ADDR 32'hFFFFA400
`define ARD_LSRAM_CTRL_ADDR 32'hFFFFA404
`define ARD_IDENT_ADDR      32'hFFFFA40C
`define ARD_IO_CFG_ADDR     32'hFFFFA410
`define ARD_LCD_BIT_ADDR    32'hFFFFA414
`define ARD_STATUS_ADDR     32'hFFFFA418

`define ARD_PER_GRP_LSB   10
`define ARD_PER_GRP_MSB   12

`define ARD_CFG_SEG       0
`define ARD_CFG_BANK      1
`define ARD_CFG_CACHE     2
`define ARD_CFG_LSRAM     3
`define ARD_CFG_IDENT     4
`define ARD_CFG_IO        5
`define ARD_CFG_LCD       6
`define ARD_CFG_INTC      7
`define ARD_CFG_CLK       8

`define ARD_PLACE_BIT     1
`define ARD_PLACE_RST     8'h02
`define ARD_CACHE_RST     8'h00
`define ARD_CACHE_SRAM_BIT 0
`define ARD_BYTE_LANE     0
`define ARD_BYTE_MSB      7
`define ARD_BYTE_LSB      0

`define ARD_SD_SUPER      0
`define ARD_SD_USER       1
`define ARD_SD_CACHE      2
`define ARD_SD_HALF       3
`define ARD_SD_BANK_LSB   4
`define ARD_SD_BANK_MSB   6

`define ARD_RESP_OKAY     2'b00
`define ARD_ZERO32        32'h00000000
`define ARD_ZERO24        24'h000000
`define ARD_ZERO23        23'h000000

`endif

// [logic/ard_span_hit.v]
// Inclusive address range comparator.
// Assumes LO is not above HI and both are 32-bit byte addresses.
module ard_span_hit #(
  parameter [31:0] LO = 32'h00000000,
  parameter [31:0] HI = 32'hFFFFFFFF
) (
  input  wire [31:0] addr,
  output wire        hit
);
  assign hit = (addr >= LO) && (addr <= HI);
endmodule // ard_span_hit

// [verification/ard_monitor.sv]
// Checker for the core-side decode outputs of the address region decoder.
// Assumes it is bound into ard_region_decoder and sees only its ports.
module ard_monitor (
  input logic        ref_clk,
  input logic        rst_n,
  input logic        core_req,
  input logic [31:0] core_addr,
  input logic        core_super,
  input logic [15:0] segment_descriptor,
  input logic        dec_valid_r,
  input logic        vector_hit_r,
  input logic [2:0]  vector_num_r,
  input logic        lsram_sel_r,
  input logic        cache_ram_sel_r,
  input logic [8:0]  cfg_grp_sel_r,
  input logic [7:0]  per_grp_sel_r,
  input logic        ext_sel_r,
  input logic [2:0]  ext_bank_r,
  input logic        ext_cacheable_r,
  input logic        ext_halfword_r,
  input logic        reserved_hit_r,
  input logic        priv_fault_r
);
  timeunit 1ns;
  timeprecision 1ps;
  wire priv = core_super ? segment_descriptor[0] : segment_descriptor[1];
  wire ok   = core_req && priv;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  chk_one_result: assert property (core_req |=> dec_valid_r ##1 (dec_valid_r == $past(core_req)))
    else $error("decode result not one cycle after request");
  chk_vector_num: assert property (ok && core_addr <= 32'h1F |=> vector_hit_r && vector_num_r == $past(core_addr[4:2]))
    else $error("vector number wrong");
  chk_vector_served: assert property (ok && core_addr <= 32'h1F |=> lsram_sel_r != ext_sel_r)
    else $error("vector fetch not served by exactly one target");
  chk_lsram_span: assert property (lsram_sel_r |-> $past(core_addr) <= 32'h7FF ||
    ($past(core_addr) >= 32'h60000000 && $past(core_addr) <= 32'h600007FF)) else $error("local SRAM outside span");
  chk_cram_span: assert property (cache_ram_sel_r |-> $past(core_addr) >= 32'h60000800 &&
    $past(core_addr) <= 32'h60000FFF) else $error("cache RAM outside span");
  chk_onchip_internal: assert property (core_req && core_addr >= 32'hFFFF0000 |=> !ext_sel_r && ext_bank_r == 3'h0 &&
    !ext_cacheable_r && !ext_halfword_r) else $error("on-chip access leaked to banks");
  chk_priv_block: assert property (core_req && !priv |=> priv_fault_r && cfg_grp_sel_r == 9'h0 &&
    per_grp_sel_r == 8'h0 && !lsram_sel_r && !cache_ram_sel_r && !ext_sel_r) else $error("privilege not enforced");
  chk_cfg_region: assert property (cfg_grp_sel_r != 9'h0 |-> $past(core_addr) >= 32'hFFFFA000)
    else $error("config group outside region");
  chk_seg_group: assert property (ok && core_addr[31:8] == 24'hFFFFA0 |=> cfg_grp_sel_r == 9'h001)
    else $error("segment group not selected");
  chk_clk_group: assert property (ok && core_addr >= 32'hFFFFAC00 && core_addr <= 32'hFFFFAFFF |=>
    cfg_grp_sel_r == 9'h100) else $error("clock group not selected");
  chk_per_group: assert property (ok && core_addr >= 32'hFFFF0000 && core_addr <= 32'hFFFF1FFF |=>
    per_grp_sel_r == (8'h01 << $past(core_addr[12:10])) && cfg_grp_sel_r == 9'h0) else $error("peripheral group wrong");
  chk_reserved: assert property (ok && core_addr >= 32'h60001000 && core_addr <= 32'h600017FF |=> reserved_hit_r &&
    !ext_sel_r && cfg_grp_sel_r == 9'h0) else $error("reserved span selected a target");
endmodule // ard_monitor

bind ard_region_decoder ard_monitor u_mon (.ref_clk, .rst_n, .core_req, .core_addr, .core_super, .segment_descriptor,
  .dec_valid_r, .vector_hit_r, .vector_num_r, .lsram_sel_r, .cache_ram_sel_r, .cfg_grp_sel_r, .per_grp_sel_r,
  .ext_sel_r, .ext_bank_r, .ext_cacheable_r, .ext_halfword_r, .reserved_hit_r, .priv_fault_r);

// [verification/ard_core_model.sv]
// Behavioural core issuing decode requests.
// Assumes the bench calls its tasks one after another on ref_clk.
module ard_core_model (
  input  logic        ref_clk,
  output logic        core_req,
  output logic [31:0] core_addr,
  output logic        core_super,
  output logic [15:0] segment_descriptor
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    core_req = 1'b0;
    core_addr = 32'h0;
    core_super = 1'b0;
    segment_descriptor = 16'h0;
  end
  task automatic drive(input logic [31:0] a, input logic s, input logic [15:0] d);
    @(posedge ref_clk);
    core_req <= 1'b1;
    core_addr <= a;
    core_super <= s;
    segment_descriptor <= d;
  endtask
  // Address and descriptor lines flip while idle so a decoder that looks at them outside a request is caught.
  task automatic idle();
    @(posedge ref_clk);
    core_req <= 1'b0;
    core_addr <= ~core_addr;
    segment_descriptor <= ~segment_descriptor;
  endtask
endmodule // ard_core_model

// [verification/testbench.sv]
// Self-checking bench for the address region decoder.
// Assumes the core model drives decode requests and the bench is the AXI4-Lite master.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [31:0] a; logic s; logic [15:0] d; logic [2:0] f; logic [8:0] c; logic [7:0] p;
    logic [2:0] t;} ard_row_t;
  logic        ref_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        core_req, core_super, dec_valid_r, vector_hit_r, lsram_sel_r, cache_ram_sel_r, ext_sel_r;
  logic        ext_cacheable_r, ext_halfword_r, reserved_hit_r, priv_fault_r;
  logic [31:0] core_addr;
  logic [15:0] segment_descriptor;
  logic [2:0]  vector_num_r, ext_bank_r;
  logic [8:0]  cfg_grp_sel_r;
  logic [7:0]  per_grp_sel_r;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  int          miscompares = 0;
  int          num_checks = 0;
  wire  [22:0] got = {vector_hit_r, lsram_sel_r, cache_ram_sel_r, cfg_grp_sel_r, per_grp_sel_r, ext_sel_r,
    reserved_hit_r, priv_fault_r};
  ard_row_t rows [21] = '{
    '{32'h00000008, 1'b1, 16'h3, 3'h4, 9'h0, 8'h0, 3'h4}, '{32'h60000010, 1'b1, 16'h3, 3'h2, 9'h0, 8'h0, 3'h0},
    '{32'h60000800, 1'b1, 16'h3, 3'h0, 9'h0, 8'h0, 3'h4}, '{32'h600017FC, 1'b1, 16'h3, 3'h0, 9'h0, 8'h0, 3'h2},
    '{32'hFFFFA0FC, 1'b1, 16'h3, 3'h0, 9'h1, 8'h0, 3'h0}, '{32'hFFFFA100, 1'b1, 16'h3, 3'h0, 9'h2, 8'h0, 3'h0},
    '{32'hFFFFA3FC, 1'b1, 16'h3, 3'h0, 9'h0, 8'h0, 3'h2}, '{32'hFFFFA400, 1'b1, 16'h3, 3'h0, 9'h4, 8'h0, 3'h0},
    '{32'hFFFFA404, 1'b1, 16'h3, 3'h0, 9'h8, 8'h0, 3'h0}, '{32'hFFFFA408, 1'b1, 16'h3, 3'h0, 9'h0, 8'h0, 3'h2},
    '{32'hFFFFA40C, 1'b1, 16'h3, 3'h0, 9'h10, 8'h0, 3'h0}, '{32'hFFFFA410, 1'b1, 16'h3, 3'h0, 9'h20, 8'h0, 3'h0},
    '{32'hFFFFA414, 1'b1, 16'h3, 3'h0, 9'h40, 8'h0, 3'h0}, '{32'hFFFFA800, 1'b1, 16'h3, 3'h0, 9'h80, 8'h0, 3'h0},
    '{32'hFFFFAFFC, 1'b1, 16'h3, 3'h0, 9'h100, 8'h0, 3'h0}, '{32'hFFFFB000, 1'b1, 16'h3, 3'h0, 9'h0, 8'h0, 3'h2},
    '{32'hFFFF2000, 1'b1, 16'h3, 3'h0, 9'h0, 8'h0, 3'h2}, '{32'hFFFFA404, 1'b0, 16'h1, 3'h0, 9'h0, 8'h0, 3'h1},
    '{32'hFFFF1C00, 1'b0, 16'h2, 3'h0, 9'h0, 8'h80, 3'h0}, '{32'hFFFF0000, 1'b1, 16'h72, 3'h0, 9'h0, 8'h0, 3'h1},
    '{32'h10000000, 1'b1, 16'h7F, 3'h0, 9'h0, 8'h0, 3'h4}};
  ard_region_decoder DUT (.*);
  ard_core_model core (.*);
  always #5 ref_clk = ~ref_clk;
  task automatic summarize();
    if (miscompares == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic cmp_dec(input logic [22:0] g, input logic [22:0] e);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %0t decode got %h exp %h", $time, g, e);
    end
  endtask
  task automatic cmp_reg(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %0t value got %h exp %h", $time, g, e);
    end
  endtask
  task automatic dec(input ard_row_t r);
    core.drive(r.a, r.s, r.d);
    core.idle();
    #1 cmp_dec(got, {r.f, r.c, r.p, r.t});
    cmp_reg({31'h0, dec_valid_r}, 32'h1);
  endtask
  task automatic axw(input logic [31:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    logic [1:0] rs;
    @(posedge ref_clk);
    {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, d, 3'h7};
    do begin
      @(negedge ref_clk);
      {ta, tw, tb, rs} = {s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_bresp};
      @(posedge ref_clk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end while (!tb);
    s_axi_bready <= 1'b0;
    cmp_reg({30'h0, rs}, 32'h0);
  endtask
  task automatic axr(input logic [31:0] a, input logic [31:0] e);
    logic ta, tr;
    logic [1:0] rs;
    logic [31:0] d;
    @(posedge ref_clk);
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
    do begin
      @(negedge ref_clk);
      {ta, tr, d, rs} = {s_axi_arready, s_axi_rvalid, s_axi_rdata, s_axi_rresp};
      @(posedge ref_clk);
      if (ta) s_axi_arvalid <= 1'b0;
    end while (!tr);
    s_axi_rready <= 1'b0;
    cmp_reg(d, e);
    cmp_reg({30'h0, rs}, 32'h0);
  endtask
  initial begin
    repeat (20000) @(posedge ref_clk);
    miscompares++;
    summarize();
  end
  initial begin
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    foreach (rows[i]) dec(rows[i]);
    for (int i = 0; i < 8; i++) dec('{32'hFFFF0000 + 32'(i) * 32'h400, 1'b1, 16'h3, 3'h0, 9'h0, 8'h01 << i, 3'h0});
    axr(32'hFFFFA404, 32'h02);
    axr(32'hFFFFA400, 32'h00);
    axr(32'hFFFFA408, 32'h00);
    axw(32'hFFFFA404, 32'h00);
    axr(32'hFFFFA404, 32'h00);
    s_axi_wstrb <= 4'hE;
    axw(32'hFFFFA404, 32'h02);
    axr(32'hFFFFA404, 32'h00);
    s_axi_wstrb <= 4'hF;
    dec('{32'h0000001C, 1'b1, 16'h3, 3'h6, 9'h0, 8'h0, 3'h0});
    cmp_reg({29'h0, vector_num_r}, 32'h7);
    core.drive(32'h0000001C, 1'b1, 16'h3);
    axr(32'hFFFFA418, 32'h1F);
    core.idle();
    dec('{32'h000007FC, 1'b0, 16'h2, 3'h2, 9'h0, 8'h0, 3'h0});
    dec('{32'h60000000, 1'b1, 16'h3, 3'h0, 9'h0, 8'h0, 3'h4});
    axw(32'hFFFFA400, 32'h01);
    dec('{32'h60000FFC, 1'b0, 16'h2, 3'h1, 9'h0, 8'h0, 3'h0});
    dec('{32'h60000800, 1'b0, 16'h1, 3'h0, 9'h0, 8'h0, 3'h1});
    axw(32'hFFFFA408, 32'hFF);
    axr(32'hFFFFA408, 32'h00);
    dec('{32'h10000000, 1'b1, 16'h7F, 3'h0, 9'h0, 8'h0, 3'h4});
    cmp_reg({27'h0, ext_bank_r, ext_cacheable_r, ext_halfword_r}, 32'h1F);
    core.drive(32'hFFFFA404, 1'b1, 16'h7F);
    core.drive(32'hFFFF0400, 1'b1, 16'h3);
    #1 cmp_dec(got, {3'h0, 9'h8, 8'h0, 3'h0});
    cmp_reg({27'h0, ext_bank_r, ext_cacheable_r, ext_halfword_r}, 32'h0);
    core.idle();
    #1 cmp_dec(got, {3'h0, 9'h0, 8'h2, 3'h0});
    core.drive(32'hFFFFA404, 1'b1, 16'h3);
    @(posedge ref_clk);
    rst_n <= 1'b0;
    #1 cmp_dec(got, 23'h0);
    core.idle();
    @(posedge ref_clk);
    rst_n <= 1'b1;
    axr(32'hFFFFA404, 32'h02);
    axr(32'hFFFFA400, 32'h00);
    summarize();
  end
endmodule // testbench
